// File: src/modem_consts.svh
`ifndef MODEM_CONSTS_SVH
`define MODEM_CONSTS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define MODEM_CLK_MHZ 50
`define MODEM_BAUD 1200
`define MODEM_BIT_CYC (`MODEM_CLK_MHZ * 1000000 / `MODEM_BAUD)
`define MODEM_LONG_US 500
`define MODEM_SHORT_US 250
`define MODEM_LONG_CYC (`MODEM_LONG_US * `MODEM_CLK_MHZ)
`define MODEM_SHORT_CYC (`MODEM_SHORT_US * `MODEM_CLK_MHZ)
`define MODEM_STARTUP_MS 32
`define MODEM_STARTUP_CYC (`MODEM_STARTUP_MS * 1000 * `MODEM_CLK_MHZ)
// Receive classification window for one half-cycle
`define MODEM_MIN_US 125
`define MODEM_SPLIT_US 375
`define MODEM_MAX_US 750
`define MODEM_MIN_CYC (`MODEM_MIN_US * `MODEM_CLK_MHZ)
`define MODEM_SPLIT_CYC (`MODEM_SPLIT_US * `MODEM_CLK_MHZ)
`define MODEM_MAX_CYC (`MODEM_MAX_US * `MODEM_CLK_MHZ)

// ----------------------------------------
// Packet format
// ----------------------------------------
`define MODEM_FIFO_DEPTH 32
`define MODEM_SYNC_HC 12
`define MODEM_DATA_HC 48
`define MODEM_SLOTS 3
// 1 = long half-cycle, first half-cycle in the MSB
`define MODEM_SYNC_PAT 12'h801
`define MODEM_NULL_GROUP 4'hf
`define MODEM_CODE_0 4'h3
`define MODEM_CODE_1 4'h5
`define MODEM_CODE_2 4'ha
`define MODEM_CODE_3 4'hc

`endif

// File: src/modem_pkg.sv
package modem_pkg;

   typedef enum logic [1:0] {
      TX_IDLE = 2'h0,
      TX_STARTUP = 2'h1,
      TX_SYNC = 2'h2,
      TX_DATA = 2'h3
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_HUNT = 2'h0,
      RX_RECV = 2'h1,
      RX_PUSH = 2'h2
   } rx_state_t;

   typedef struct packed {
      logic sin_s1;
      logic sin_s2;
      logic hold_s1;
      logic hold_s2;
      logic tin_s1;
      logic tin_s2;
      logic tin_prev;
      logic urx_busy;
      logic [15:0] urx_cnt;
      logic [3:0] urx_bit;
      logic [7:0] urx_sh;
      logic urx_push;
      tx_state_t tx_state;
      logic tone;
      logic key;
      logic [14:0] hc_cnt;
      logic [20:0] timer;
      logic [5:0] idx;
      logic [2:0][7:0] slots;
      logic [1:0] slot_n;
      rx_state_t rx_state;
      logic [15:0] per_cnt;
      logic [11:0] hist;
      logic [3:0] hist_n;
      logic [2:0] grp;
      logic [5:0] sym_n;
      logic [2:0][7:0] rbytes;
      logic [2:0] rdat;
      logic [2:0] rnull;
      logic [2:0] rvalid;
      logic [1:0] push_i;
      logic utx_busy;
      logic [15:0] utx_cnt;
      logic [3:0] utx_bit;
      logic [9:0] utx_sh;
      logic sout;
   } modem_state_t;

endpackage : modem_pkg

// File: src/stream_fifo.sv
`timescale 1ns/1ns
module stream_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_check
      $error("stream_fifo: DEPTH must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wr;
      logic [AW:0] rd;
   } fifo_state_t;

   fifo_state_t st;
   fifo_state_t next_st;
   logic full;
   logic empty;

   // Extra pointer bit tells full from empty
   assign full = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
   assign empty = (st.wr == st.rd);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = st.mem[st.rd[AW-1:0]];

   always_comb begin
      next_st = st;
      if (in_valid_i && !full) begin
         next_st.mem[st.wr[AW-1:0]] = in_data_i;
         next_st.wr = st.wr + 1'b1;
      end
      if (out_ready_i && !empty) begin
         next_st.rd = st.rd + 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : stream_fifo

// File: src/tone_burst_radio_modem.sv
// Behaviour
// R1: Host serial is 1200 baud, 8N1, both ways
// R2: Transmit and receive each buffer 32 bytes
// R3: Key radio on data, buffer through startup
// R4: Packet is sync plus three byte slots
// R5: Empty slots sent as idle pattern
// R6: Key radio off once buffer is empty
// R7: Half-cycles last 500 us or 250 us
// R8: Idle and preamble send long half-cycles only
// R9: Sync LSSSSSSSSSSL then twelve four-half-cycle groups
// R10: Group carries two bits, byte spans four groups
// R11: Only four group codes carry data
// R12: Any other non-idle group drops packet
// R13: All-long group is null, packet kept; the code drops the packet if one slot mixes null and data groups
// R14: Output only after recognised sync code
// R15: Received bytes buffered, sent at steady rate
// R16: No correction or retry, bad packets dropped
// R17: Host may hold low for continuous transmission
// R18: Code table and bit order shared both ends
// R19: Classify half-cycles by threshold, reject outliers
`timescale 1ns/1ns
`include "modem_consts.svh"
module tone_burst_radio_modem #(
   parameter int BIT_CYC = `MODEM_BIT_CYC,
   parameter int LONG_CYC = `MODEM_LONG_CYC,
   parameter int SHORT_CYC = `MODEM_SHORT_CYC,
   parameter int STARTUP_CYC = `MODEM_STARTUP_CYC,
   parameter int MIN_CYC = `MODEM_MIN_CYC,
   parameter int SPLIT_CYC = `MODEM_SPLIT_CYC,
   parameter int MAX_CYC = `MODEM_MAX_CYC,
   parameter int FIFO_DEPTH = `MODEM_FIFO_DEPTH
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic modem_serial_in_i,
   input wire logic transmit_hold_n_i,
   input wire logic tone_in_i,
   output logic modem_serial_out_o,
   output logic radio_key_o,
   output logic tone_o
);
   if (BIT_CYC < 4 || BIT_CYC > 65535 || SHORT_CYC < 1 || SHORT_CYC >= LONG_CYC
       || LONG_CYC > 32767 || STARTUP_CYC > 2097151 || MIN_CYC >= SPLIT_CYC
       || SPLIT_CYC >= MAX_CYC || MAX_CYC > 65534) begin : g_check
      $error("tone_burst_radio_modem: timing parameters out of range");
   end

   localparam logic [15:0] BIT_N = 16'(BIT_CYC);
   localparam logic [15:0] HALF_N = 16'(BIT_CYC / 2);
   localparam logic [14:0] LONG_N = 15'(LONG_CYC);
   localparam logic [14:0] SHORT_N = 15'(SHORT_CYC);
   localparam logic [20:0] STARTUP_N = 21'(STARTUP_CYC);
   localparam logic [15:0] MIN_N = 16'(MIN_CYC);
   localparam logic [15:0] SPLIT_N = 16'(SPLIT_CYC);
   localparam logic [15:0] MAX_N = 16'(MAX_CYC);
   localparam logic [5:0] SYNC_LAST = 6'(`MODEM_SYNC_HC - 1);
   localparam logic [5:0] DATA_LAST = 6'(`MODEM_DATA_HC - 1);
   localparam logic [1:0] SLOTS = 2'(`MODEM_SLOTS);

   localparam modem_pkg::modem_state_t RESET_ST = '{
      sin_s1: 1'b1, sin_s2: 1'b1, hold_s1: 1'b1, hold_s2: 1'b1, sout: 1'b1,
      tx_state: modem_pkg::TX_IDLE, rx_state: modem_pkg::RX_HUNT, default: '0};

   modem_pkg::modem_state_t st;
   modem_pkg::modem_state_t next_st;

   logic tx_in_ready;
   logic tx_out_valid;
   logic [7:0] tx_out_data;
   logic tx_pop;
   logic rx_in_valid;
   logic rx_in_ready;
   logic [7:0] rx_in_data;
   logic rx_out_valid;
   logic [7:0] rx_out_data;
   logic rx_pop;
   logic edge_seen;
   logic sym_ok;
   logic sym_l;
   logic [3:0] code;
   logic [2:0] dec;
   logic [1:0] slot;

   // ----------------------------------------
   // Group coding
   // ----------------------------------------
   function automatic logic [3:0] enc(input logic [1:0] bits);
      unique case (bits) // [R11] [R18]
         2'h0: return `MODEM_CODE_0;
         2'h1: return `MODEM_CODE_1;
         2'h2: return `MODEM_CODE_2;
         2'h3: return `MODEM_CODE_3;
      endcase
   endfunction : enc

   // Returns {valid, bits}
   function automatic logic [2:0] decode(input logic [3:0] c);
      unique case (c) // [R11] [R18]
         `MODEM_CODE_0: return 3'h4;
         `MODEM_CODE_1: return 3'h5;
         `MODEM_CODE_2: return 3'h6;
         `MODEM_CODE_3: return 3'h7;
         default: return 3'h0;
      endcase
   endfunction : decode

   // Long or short for data half-cycle i; low bit pair of a byte goes first
   function automatic logic data_long(input logic [5:0] i, input logic [1:0] n,
                                      input logic [2:0][7:0] b);
      logic [3:0] c;
      c = enc(2'(b[i[5:4]] >> {i[3:2], 1'b0})); // [R10] [R18]
      return (i[5:4] >= n) ? 1'b1 : c[~i[1:0]]; // [R5]
   endfunction : data_long

   // ----------------------------------------
   // Buffers
   // ----------------------------------------
   stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo ( // [R2] [R3]
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .in_valid_i(st.urx_push),
      .in_ready_o(tx_in_ready),
      .in_data_i(st.urx_sh),
      .out_valid_o(tx_out_valid),
      .out_ready_i(tx_pop),
      .out_data_o(tx_out_data)
   );

   stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo ( // [R2] [R15]
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .in_valid_i(rx_in_valid),
      .in_ready_o(rx_in_ready),
      .in_data_i(rx_in_data),
      .out_valid_o(rx_out_valid),
      .out_ready_i(rx_pop),
      .out_data_o(rx_out_data)
   );

   always_comb begin
      next_st = st;
      tx_pop = 1'b0;
      rx_in_valid = 1'b0;
      rx_in_data = st.rbytes[st.push_i];
      rx_pop = 1'b0;
      code = 4'h0;
      dec = 3'h0;
      slot = st.sym_n[5:4];
      sym_ok = (st.per_cnt >= MIN_N) && (st.per_cnt <= MAX_N); // [R19]
      sym_l = (st.per_cnt >= SPLIT_N); // [R19]
      edge_seen = (st.tin_s2 != st.tin_prev);

      next_st.sin_s1 = modem_serial_in_i;
      next_st.sin_s2 = st.sin_s1;
      next_st.hold_s1 = transmit_hold_n_i;
      next_st.hold_s2 = st.hold_s1;
      next_st.tin_s1 = tone_in_i;
      next_st.tin_s2 = st.tin_s1;
      next_st.tin_prev = st.tin_s2;

      // ----------------------------------------
      // Host serial receiver
      // ----------------------------------------
      next_st.urx_push = 1'b0;
      if (!st.urx_busy) begin
         if (!st.sin_s2) begin
            next_st.urx_busy = 1'b1;
            next_st.urx_cnt = HALF_N;
            next_st.urx_bit = 4'h0;
         end
      end else if (st.urx_cnt != 16'h0) begin
         next_st.urx_cnt = st.urx_cnt - 16'h1;
      end else begin
         next_st.urx_cnt = BIT_N - 16'h1;
         next_st.urx_bit = st.urx_bit + 4'h1;
         if (st.urx_bit == 4'h0) begin
            // Glitch rather than a start bit
            next_st.urx_busy = !st.sin_s2;
         end else if (st.urx_bit < 4'h9) begin
            next_st.urx_sh = {st.sin_s2, st.urx_sh[7:1]}; // [R1]
         end else begin
            // Bad stop bit or full buffer: byte lost, host has no flow control
            next_st.urx_busy = 1'b0;
            next_st.urx_push = st.sin_s2 && tx_in_ready; // [R1]
         end
      end

      // ----------------------------------------
      // Packet coder
      // ----------------------------------------
      tx_pop = (st.tx_state == modem_pkg::TX_SYNC) && (st.slot_n != SLOTS) && tx_out_valid;
      if (tx_pop) begin
         next_st.slots[st.slot_n] = tx_out_data; // [R4]
         next_st.slot_n = st.slot_n + 2'h1;
      end
      if (st.tx_state == modem_pkg::TX_IDLE) begin
         if (tx_out_valid || !st.hold_s2) begin // [R3] [R17]
            next_st.tx_state = modem_pkg::TX_STARTUP;
            next_st.key = 1'b1;
            next_st.timer = STARTUP_N;
            next_st.hc_cnt = LONG_N - 15'h1; // [R8]
            next_st.tone = 1'b1;
         end
      end else begin
         if (st.timer != 21'h0) begin
            next_st.timer = st.timer - 21'h1;
         end
         if (st.hc_cnt != 15'h0) begin
            next_st.hc_cnt = st.hc_cnt - 15'h1;
         end else begin
            next_st.tone = !st.tone;
            next_st.hc_cnt = LONG_N - 15'h1; // [R7] [R8]
            unique case (st.tx_state)
               modem_pkg::TX_STARTUP: begin
                  // Preamble of long half-cycles covers radio start-up
                  if (st.timer == 21'h0) begin // [R3]
                     next_st.tx_state = modem_pkg::TX_SYNC;
                     next_st.idx = 6'h0;
                     next_st.slot_n = 2'h0;
                  end
               end
               modem_pkg::TX_SYNC: begin
                  next_st.idx = st.idx + 6'h1;
                  if (st.idx == SYNC_LAST) begin // [R4] [R9]
                     next_st.tx_state = modem_pkg::TX_DATA;
                     next_st.idx = 6'h0;
                     if (!data_long(6'h0, st.slot_n, st.slots)) begin
                        next_st.hc_cnt = SHORT_N - 15'h1;
                     end
                  end else if (st.idx + 6'h1 != SYNC_LAST) begin
                     next_st.hc_cnt = SHORT_N - 15'h1; // [R7] [R9]
                  end
               end
               modem_pkg::TX_DATA: begin
                  next_st.idx = st.idx + 6'h1;
                  if (st.idx == DATA_LAST) begin
                     if (tx_out_valid || !st.hold_s2) begin // [R4] [R17]
                        next_st.tx_state = modem_pkg::TX_SYNC;
                        next_st.idx = 6'h0;
                        next_st.slot_n = 2'h0;
                     end else begin
                        next_st.tx_state = modem_pkg::TX_IDLE; // [R6]
                        next_st.key = 1'b0;
                        next_st.tone = 1'b0;
                     end
                  end else if (!data_long(st.idx + 6'h1, st.slot_n, st.slots)) begin
                     next_st.hc_cnt = SHORT_N - 15'h1; // [R7] [R10]
                  end
               end
               modem_pkg::TX_IDLE: begin
               end
            endcase
         end
      end

      // ----------------------------------------
      // Packet decoder
      // ----------------------------------------
      if (edge_seen) begin
         next_st.per_cnt = 16'h1;
      end else if (st.per_cnt != 16'hffff) begin
         next_st.per_cnt = st.per_cnt + 16'h1;
      end
      unique case (st.rx_state)
         modem_pkg::RX_HUNT: begin
            if (edge_seen) begin
               if (!sym_ok) begin
                  next_st.hist_n = 4'h0; // [R19]
               end else begin
                  next_st.hist = {st.hist[10:0], sym_l};
                  if (st.hist_n != 4'hc) begin
                     next_st.hist_n = st.hist_n + 4'h1;
                  end
                  // Noise never gets past here without a full sync match
                  if (st.hist_n >= 4'hb && {st.hist[10:0], sym_l} == `MODEM_SYNC_PAT) begin
                     next_st.rx_state = modem_pkg::RX_RECV; // [R9] [R14]
                     next_st.sym_n = 6'h0;
                     next_st.rdat = 3'h0;
                     next_st.rnull = 3'h0;
                     next_st.hist_n = 4'h0;
                  end
               end
            end
         end
         modem_pkg::RX_RECV: begin
            if (st.per_cnt > MAX_N || (edge_seen && !sym_ok)) begin
               next_st.rx_state = modem_pkg::RX_HUNT; // [R16] [R19]
            end else if (edge_seen) begin
               next_st.grp = {st.grp[1:0], sym_l};
               next_st.sym_n = st.sym_n + 6'h1;
               if (st.sym_n[1:0] == 2'h3) begin
                  code = {st.grp, sym_l};
                  dec = decode(code);
                  if (code == `MODEM_NULL_GROUP) begin
                     next_st.rnull[slot] = 1'b1; // [R13]
                  end else if (dec[2]) begin
                     next_st.rdat[slot] = 1'b1; // [R10]
                     next_st.rbytes[slot] = {dec[1:0], st.rbytes[slot][7:2]};
                  end else begin
                     next_st.rx_state = modem_pkg::RX_HUNT; // [R12] [R16]
                  end
                  if (dec[2] || code == `MODEM_NULL_GROUP) begin
                     if (st.sym_n == DATA_LAST) begin
                        // A slot mixing null and data groups is corrupt
                        if ((next_st.rdat & next_st.rnull) != 3'h0) begin
                           next_st.rx_state = modem_pkg::RX_HUNT; // [R12]
                        end else begin
                           next_st.rx_state = modem_pkg::RX_PUSH; // [R13]
                           next_st.rvalid = next_st.rdat;
                           next_st.push_i = 2'h0;
                        end
                     end
                  end
               end
            end
         end
         modem_pkg::RX_PUSH: begin
            // Edges seen here are lost; a sync edge lost while the buffer is full drops the following packet whole
            if (st.push_i == SLOTS) begin
               next_st.rx_state = modem_pkg::RX_HUNT;
            end else if (!st.rvalid[st.push_i]) begin
               next_st.push_i = st.push_i + 2'h1;
            end else begin
               rx_in_valid = 1'b1; // [R15]
               if (rx_in_ready) begin
                  next_st.push_i = st.push_i + 2'h1;
               end
            end
         end
         default: begin
            next_st.rx_state = modem_pkg::RX_HUNT;
         end
      endcase

      // ----------------------------------------
      // Host serial transmitter
      // ----------------------------------------
      if (!st.utx_busy) begin
         next_st.sout = 1'b1;
         if (rx_out_valid) begin
            rx_pop = 1'b1; // [R15]
            next_st.utx_busy = 1'b1;
            next_st.utx_sh = {1'b1, rx_out_data, 1'b0}; // [R1]
            next_st.utx_cnt = BIT_N - 16'h1;
            next_st.utx_bit = 4'h0;
            next_st.sout = 1'b0;
         end
      end else if (st.utx_cnt != 16'h0) begin
         next_st.utx_cnt = st.utx_cnt - 16'h1;
      end else if (st.utx_bit == 4'h9) begin
         next_st.utx_busy = 1'b0;
      end else begin
         next_st.utx_cnt = BIT_N - 16'h1;
         next_st.utx_bit = st.utx_bit + 4'h1;
         next_st.utx_sh = {1'b1, st.utx_sh[9:1]};
         next_st.sout = st.utx_sh[1]; // [R1]
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= RESET_ST;
      end else begin
         st <= next_st;
      end
   end

   assign modem_serial_out_o = st.sout;
   assign radio_key_o = st.key;
   assign tone_o = st.tone;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   property p_key_on;
      $rose(st.key) |-> $past(tx_out_valid || !st.hold_s2) ##0 st.tone;
   endproperty
   a_key_on: assert property (p_key_on) else $error("Radio keyed without cause"); // [R3]

   property p_key_off;
      $fell(st.key) |-> $past(!tx_out_valid && st.hold_s2 && st.idx == DATA_LAST);
   endproperty
   a_key_off: assert property (p_key_off) else $error("Radio unkeyed early"); // [R6]

   property p_preamble_long;
      st.tx_state == modem_pkg::TX_STARTUP && st.hc_cnt == 15'h0 |=>
         st.hc_cnt == LONG_N - 15'h1 && st.tone != $past(st.tone);
   endproperty
   a_preamble_long: assert property (p_preamble_long) else $error("Preamble not long"); // [R8]

   property p_sync_short;
      st.tx_state == modem_pkg::TX_SYNC && $changed(st.idx) && st.idx != 6'h0
         && st.idx != SYNC_LAST |-> st.hc_cnt == SHORT_N - 15'h1;
   endproperty
   a_sync_short: assert property (p_sync_short) else $error("Sync middle not short"); // [R9]

   property p_sync_to_data;
      st.tx_state == modem_pkg::TX_SYNC && st.idx == SYNC_LAST && st.hc_cnt == 15'h0 |=>
         st.tx_state == modem_pkg::TX_DATA && st.idx == 6'h0;
   endproperty
   a_sync_to_data: assert property (p_sync_to_data) else $error("Sync length wrong"); // [R4]

   property p_null_slot;
      st.tx_state == modem_pkg::TX_DATA && $changed(st.idx) && st.idx[5:4] >= st.slot_n
         |-> st.hc_cnt == LONG_N - 15'h1;
   endproperty
   a_null_slot: assert property (p_null_slot) else $error("Empty slot not idle"); // [R5]

   property p_push_after_packet;
      $rose(st.rx_state == modem_pkg::RX_PUSH) |->
         $past(st.rx_state) == modem_pkg::RX_RECV && $past(st.sym_n) == DATA_LAST;
   endproperty
   a_push_after_packet: assert property (p_push_after_packet) else $error("Push w/o packet"); // [R14]

   property p_push_only;
      rx_in_valid |-> st.rx_state == modem_pkg::RX_PUSH && st.rvalid[st.push_i];
   endproperty
   a_push_only: assert property (p_push_only) else $error("Stray receive byte"); // [R12]

   property p_silence_abort;
      st.rx_state == modem_pkg::RX_RECV && st.per_cnt > MAX_N |=>
         st.rx_state == modem_pkg::RX_HUNT;
   endproperty
   a_silence_abort: assert property (p_silence_abort) else $error("Lost tone kept"); // [R19]

   property p_stop_bit;
      st.utx_busy && st.utx_bit == 4'h9 |-> st.sout && $past(st.sout) == $past(st.utx_sh[0]);
   endproperty
   a_stop_bit: assert property (p_stop_bit) else $error("Stop bit not high"); // [R1]

   c_packet_sent: cover property (st.tx_state == modem_pkg::TX_DATA && st.idx == DATA_LAST);
   c_rx_push: cover property (rx_in_valid && rx_in_ready);
   c_key_off: cover property ($fell(st.key));
   c_byte_out: cover property (rx_pop);
endmodule : tone_burst_radio_modem

// File: tb/far_side.sv
`timescale 1ns/1ns
// ----------------------------------------
// Remote radio and host serial port
// ----------------------------------------
module far_side #(
   parameter int BIT_CYC = 40
) (
   input wire logic clock_i,
   input wire logic key_i,
   input wire logic tone_i,
   input wire logic noisy_i,
   input wire logic flip_i,
   input wire logic serial_i,
   output logic tone_o
);
   logic ntog = 1'b0;
   logic [7:0] rxq[$];
   logic [7:0] b;
   // Unkeyed or jammed channel gives noise, never a held level
   always @(posedge clock_i) begin
      ntog <= ~ntog;
   end
   // Flip adds one extra edge, corrupting the group it lands in
   assign tone_o = (key_i && !noisy_i) ? tone_i ^ flip_i : ntog;
   // Host receiver, 8N1 LSB first
   initial forever begin
      @(negedge serial_i);
      repeat (BIT_CYC / 2) @(posedge clock_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge clock_i);
         b[i] = serial_i;
      end
      repeat (BIT_CYC) @(posedge clock_i);
      if (serial_i) rxq.push_back(b);
   end
endmodule : far_side

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   localparam int BIT = 40;
   localparam int LONG = 20;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic ser_in = 1'b1;
   logic hold_n = 1'b1;
   logic noisy = 1'b0;
   logic flip = 1'b0;
   logic ser_out, key, tone, tone_rx;
   int miscompares = 0;
   int tests_run = 0;

   initial forever #10 clock = ~clock;

   // Startup longer than two frames, so all three bytes wait for sync
   tone_burst_radio_modem #(.BIT_CYC(BIT), .LONG_CYC(LONG), .SHORT_CYC(10),
      .STARTUP_CYC(1200), .MIN_CYC(5), .SPLIT_CYC(15), .MAX_CYC(30)) uut (
      .clock_i(clock), .resetn_i(resetn), .modem_serial_in_i(ser_in),
      .transmit_hold_n_i(hold_n), .tone_in_i(tone_rx), .modem_serial_out_o(ser_out),
      .radio_key_o(key), .tone_o(tone));
   far_side #(.BIT_CYC(BIT)) far (.clock_i(clock), .key_i(key), .tone_i(tone),
      .noisy_i(noisy), .flip_i(flip), .serial_i(ser_out), .tone_o(tone_rx));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge clock);
         ser_in = f[i];
         repeat (BIT - 1) @(negedge clock);
      end
   endtask : send_byte

   task automatic wait_key(input logic v, input int limit);
      int n;
      n = 0;
      while (key !== v && n < limit) begin
         @(negedge clock);
         n++;
      end
      check(key, v);
   endtask : wait_key

   task automatic wait_rx(input int cnt);
      int n;
      n = 0;
      while (far.rxq.size() < cnt && n < 8000) begin
         @(negedge clock);
         n++;
      end
   endtask : wait_rx

   // Cycles from one tone edge to the next
   task automatic half_len(output int n);
      logic m;
      n = 0;
      m = tone;
      while (tone === m && n < 50) begin
         @(negedge clock);
         n++;
      end
      n = 0;
      m = tone;
      while (tone === m && n < 50) begin
         @(negedge clock);
         n++;
      end
   endtask : half_len

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_full_packet();
      int n;
      send_byte(8'ha5);
      wait_key(1'b1, 4);
      send_byte(8'h3c);
      send_byte(8'h0f);
      half_len(n);
      check(n[15:0], 16'(LONG));
      wait_rx(3);
      check(16'(far.rxq.size()), 16'h0003);
      check(far.rxq.pop_front(), 8'ha5);
      check(far.rxq.pop_front(), 8'h3c);
      check(far.rxq.pop_front(), 8'h0f);
      wait_key(1'b0, 3000);
   endtask : test_full_packet

   task automatic test_partial();
      send_byte(8'hc3);
      wait_rx(1);
      wait_key(1'b0, 3000);
      repeat (BIT * 12) @(negedge clock);
      check(16'(far.rxq.size()), 16'h0001);
      check(far.rxq.pop_front(), 8'hc3);
   endtask : test_partial

   // Long half-cycle in a null slot split into two shorts
   task automatic test_bad_group();
      logic m;
      int n;
      send_byte(8'h00);
      wait_key(1'b1, 4);
      repeat (1900) @(negedge clock);
      m = tone;
      n = 0;
      while (tone === m && n < 50) begin
         @(negedge clock);
         n++;
      end
      repeat (LONG / 2) @(negedge clock);
      flip = 1'b1;
      wait_key(1'b0, 3000);
      flip = 1'b0;
      repeat (BIT * 12) @(negedge clock);
      check(16'(far.rxq.size()), 16'h0000);
   endtask : test_bad_group

   task automatic test_noise_hold();
      noisy = 1'b1;
      hold_n = 1'b0;
      wait_key(1'b1, 10);
      repeat (3000) @(negedge clock);
      check(key, 1'b1);
      check({15'(far.rxq.size()), ser_out}, 16'h0001);
      hold_n = 1'b1;
      noisy = 1'b0;
      wait_key(1'b0, 3000);
   endtask : test_noise_hold

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (10) @(negedge clock);
      check({ser_out, key, tone}, 3'b100);
      resetn = 1'b1;
      repeat (2) @(negedge clock);
      test_full_packet();
      test_partial();
      test_bad_group();
      test_noise_hold();
      stop_test();
   end

   // Whole run needs about 14000 cycles
   initial begin
      #(20 * 60000);
      miscompares++;
      stop_test();
   end
endmodule : testbench
